/* rtl/pfs_params.svh */
// Purpose: Constants of the power stage fault supervisor
// Assumes: 250 MHz core clock
// Notes:   Included by the supervisor top only
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define PFS_CTRL_OFS        12'h000
`define PFS_STAT_OFS        12'h004
`define PFS_CTRL_RST        4'h0
`define PFS_CTRL_W          4
`define PFS_STAT_W          16

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PFS_CLK_KHZ         250000
`define PFS_OVERLOAD_US     2600
`define PFS_OVERLOAD_CYC    ((`PFS_OVERLOAD_US * `PFS_CLK_KHZ) / 1000)
`define PFS_OVL_CNT_W       20
`define PFS_PWM_LOSS_CYC    1000
`define PFS_PWM_CNT_W       10

`endif

/* rtl/pfs_pkg.sv */
// Purpose: Types of the power stage fault supervisor
// Assumes: Three strap pins select the output configuration
// Notes:   Unlisted strap codes decode to an illegal mode
package pfs_pkg;

  typedef enum logic [2:0] {
    PFS_BTL_AD,
    PFS_BTL_AD_1N,
    PFS_BTL_BD,
    PFS_BTL_SE,
    PFS_PARALLELED_BRIDGE_OUTPUT,
    PFS_SE4,
    PFS_BAD
  } pfs_mode_t;

  function automatic pfs_mode_t pfs_decode(input logic [2:0] pins);
    pfs_mode_t m;
    m = PFS_BAD;
    unique case (pins)
      3'h0:    m = PFS_BTL_AD;
      3'h1:    m = PFS_BTL_AD_1N;
      3'h2:    m = PFS_BTL_BD;
      3'h3:    m = PFS_BTL_SE;
      3'h4:    m = PFS_PARALLELED_BRIDGE_OUTPUT;
      3'h5:    m = PFS_SE4;
      default: m = PFS_BAD;
    endcase
    return m;
  endfunction

endpackage

/* rtl/pfs_supervisor.sv */
// Purpose: Fault supervisor for a four half-bridge PWM power stage
// Assumes: Inputs synchronous to core_clk except the reset pin
// Notes:   Flags are open drain, the pin level is resolved outside
//
// Behaviour
// [R1] Supply low: all outputs off, fault low
// [R2] Supply faults clear when supplies recover
// [R3] Power-on reset clears overload latches
// [R4] Reset pin low forces fault flag high
// [R5] Flags are active-low open-drain outputs
// [R6] Flag pair encodes shutdown, fault, warning
// [R7] Warning above 125 C, outputs keep switching
// [R8] Warning clears below lower hysteresis level
// [R9] Thermal trip latches global shutdown
// [R10] Channel fault stops only its channel group
// [R11] Current limit over 2.6 ms latches overload
// [R12] Lost PWM idles channel, all lost stops
// [R13] Bootstrap low turns off that high side
// [R14] Reset pin low forces all outputs off
// [R15] Reset pulls bridge outputs down, not SE
// [R16] Reset rise no sooner than 4 ms after fault
// [R17] Host releases reset only without warning
// [R18] Three-level modulation only in bridge modes
// [R19] Strap pins select mode, fixed at reset
// [R20] Thermal latch clears on reset, then resumes
// [R21] Reset pin synchronised and edge detected
`timescale 1ns/1ps
`include "pfs_params.svh"

module pfs_supervisor
  import pfs_pkg::*;
#(
  parameter int OVERLOAD_CYC = `PFS_OVERLOAD_CYC
)
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        reset_pin_n,
  input  wire logic        config_pin_0,
  input  wire logic        config_pin_1,
  input  wire logic        config_pin_2,
  input  wire logic        gate_drive_supply_low,
  input  wire logic        bridge_power_supply_low,
  input  wire logic        logic_regulator_supply_low,
  input  wire logic        analog_regulator_supply_low,
  input  wire logic        temp_above_warn,
  input  wire logic        temp_above_hyst,
  input  wire logic        thermal_trip,
  input  wire logic [3:0]  per_cycle_current_limit,
  input  wire logic [3:0]  bootstrap_cap_low,
  input  wire logic [3:0]  pwm_in,
  output logic [3:0]       high_side_on,
  output logic [3:0]       low_side_on,
  output logic [3:0]       weak_pull_down_on,
  output logic             fault_n_o,
  output logic             fault_n_oe,
  output logic             thermal_warning_n_o,
  output logic             thermal_warning_n_oe
);

  // ----------------------------------------------------------------------
  // Reset pin synchroniser and edge
  // ----------------------------------------------------------------------
  logic            pin_meta_r;
  logic            pin_s_r;
  logic            pin_prev_r;
  logic            rst_rise;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_meta_r <= 1'b0;
      pin_s_r    <= 1'b0;
      pin_prev_r <= 1'b0;
    end
    else
    begin
      pin_meta_r <= reset_pin_n;
      pin_s_r    <= pin_meta_r;
      pin_prev_r <= pin_s_r;
    end
  end

  assign rst_rise = pin_s_r & ~pin_prev_r; // [R21]

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  pfs_mode_t       mode_r;
  logic            strap_done_r;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_r       <= PFS_BAD;
      strap_done_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      mode_r       <= pfs_decode({config_pin_2, config_pin_1, config_pin_0}); // [R19] [R18]
      strap_done_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Supply and thermal state
  // ----------------------------------------------------------------------
  logic            uv_r;
  logic            warn_r;
  logic            thermal_trip_latch_r;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      uv_r <= 1'b1;
    else
      uv_r <= gate_drive_supply_low | bridge_power_supply_low
            | logic_regulator_supply_low | analog_regulator_supply_low; // [R1] [R2]
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      warn_r <= 1'b0;
    else if (temp_above_warn)
      warn_r <= 1'b1; // [R7]
    else if (!temp_above_hyst)
      warn_r <= 1'b0; // [R8]
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      thermal_trip_latch_r <= 1'b0;
    else if (thermal_trip)
      thermal_trip_latch_r <= 1'b1; // [R9]
    else if (rst_rise)
      thermal_trip_latch_r <= 1'b0; // [R20]
  end

  // ----------------------------------------------------------------------
  // Per-channel overload timer and PWM loss detector
  // ----------------------------------------------------------------------
  logic [3:0]      ovl_latch_r;
  logic [3:0]      stale_r;
  logic [3:0]      pwm_prev_r;
  logic            all_stale;

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_ch
      logic [`PFS_OVL_CNT_W-1:0] ovl_cnt_r;
      logic [`PFS_PWM_CNT_W-1:0] pwm_cnt_r;

      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
          ovl_cnt_r <= '0;
        else if (!per_cycle_current_limit[ch] || ovl_latch_r[ch])
          ovl_cnt_r <= '0;
        else
          ovl_cnt_r <= ovl_cnt_r + `PFS_OVL_CNT_W'(1);
      end

      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
          ovl_latch_r[ch] <= 1'b0; // [R3]
        else if (per_cycle_current_limit[ch]
                 && ovl_cnt_r == `PFS_OVL_CNT_W'(OVERLOAD_CYC - 1))
          ovl_latch_r[ch] <= 1'b1; // [R11]
        else if (rst_rise)
          ovl_latch_r[ch] <= 1'b0; // [R11]
      end

      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          pwm_prev_r[ch] <= 1'b0;
          pwm_cnt_r      <= '0;
          stale_r[ch]    <= 1'b1;
        end
        else
        begin
          pwm_prev_r[ch] <= pwm_in[ch];
          if (pwm_in[ch] != pwm_prev_r[ch])
          begin
            pwm_cnt_r   <= '0;
            stale_r[ch] <= 1'b0; // [R12]
          end
          else if (pwm_cnt_r == `PFS_PWM_CNT_W'(`PFS_PWM_LOSS_CYC - 1))
            stale_r[ch] <= 1'b1; // [R12]
          else
            pwm_cnt_r <= pwm_cnt_r + `PFS_PWM_CNT_W'(1);
        end
      end
    end
  endgenerate

  assign all_stale = &stale_r; // [R12]

  // ----------------------------------------------------------------------
  // APB register slave
  // ----------------------------------------------------------------------
  logic [3:0]      chan_off_r;
  logic            apb_acc;
  logic            hit_ctrl;
  logic            hit_stat;

  assign apb_acc  = psel & penable & ~pready;
  assign hit_ctrl = paddr == `PFS_CTRL_OFS;
  assign hit_stat = paddr == `PFS_STAT_OFS;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apb_acc;
      pslverr <= apb_acc & ~(hit_ctrl | (hit_stat & ~pwrite));
      prdata  <= '0;
      if (apb_acc && !pwrite && hit_ctrl)
        prdata <= {28'h0000000, chan_off_r};
      else if (apb_acc && !pwrite && hit_stat)
        prdata <= {16'h0000, mode_r, warn_r, thermal_trip_latch_r, uv_r, ovl_latch_r,
                   stale_r, 2'h0};
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      chan_off_r <= `PFS_CTRL_RST;
    else if (apb_acc && pwrite && hit_ctrl)
      chan_off_r <= pwdata[`PFS_CTRL_W-1:0];
  end

  // ----------------------------------------------------------------------
  // Output stage control
  // ----------------------------------------------------------------------
  logic            global_ok;
  logic [3:0]      grp_off;
  logic [3:0]      run;
  logic [3:0]      pd_nxt;
  logic            fault_nxt;

  assign global_ok = pin_s_r & ~uv_r & ~thermal_trip_latch_r & (mode_r != PFS_BAD)
                   & ~all_stale; // [R1] [R9] [R12] [R14]

  always_comb
  begin
    if (mode_r == PFS_PARALLELED_BRIDGE_OUTPUT)
      grp_off = {4{|ovl_latch_r}}; // [R10]
    else
      grp_off = {{2{|ovl_latch_r[3:2]}}, {2{|ovl_latch_r[1:0]}}}; // [R10]
  end

  assign run = {4{global_ok}} & ~grp_off & ~stale_r & ~chan_off_r; // [R10] [R12]

  always_comb
  begin
    pd_nxt = 4'h0;
    if (!pin_s_r)
    begin
      unique case (mode_r)
        PFS_SE4:    pd_nxt = 4'h0; // [R15]
        PFS_BTL_SE: pd_nxt = 4'h3; // [R15]
        PFS_BAD:    pd_nxt = 4'h0;
        default:    pd_nxt = 4'hF; // [R15]
      endcase
    end
  end

  assign fault_nxt = pin_s_r & (uv_r | thermal_trip_latch_r | (|ovl_latch_r)); // [R4] [R6]

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      high_side_on      <= 4'h0;
      low_side_on       <= 4'h0;
      weak_pull_down_on <= 4'h0;
    end
    else
    begin
      high_side_on      <= run & pwm_in & ~bootstrap_cap_low; // [R13] [R7]
      low_side_on       <= run & ~pwm_in; // [R14]
      weak_pull_down_on <= pd_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fault_n_o            <= 1'b0;
      fault_n_oe           <= 1'b0;
      thermal_warning_n_o  <= 1'b0;
      thermal_warning_n_oe <= 1'b0;
    end
    else
    begin
      fault_n_o            <= 1'b0; // [R5]
      fault_n_oe           <= fault_nxt; // [R1] [R4]
      thermal_warning_n_o  <= 1'b0; // [R5]
      thermal_warning_n_oe <= warn_r; // [R6] [R7]
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_uv_outputs_off: assert property (uv_r |=> high_side_on == 4'h0 && low_side_on == 4'h0) // [R1]
    else $error("outputs active during supply low");
  a_uv_fault_low: assert property (uv_r && pin_s_r |=> fault_n_oe) // [R1]
    else $error("fault flag not pulled on supply low");
  a_uv_self_clear: assert property (!uv_r && !thermal_trip_latch_r && ovl_latch_r == 4'h0
                                    |=> !fault_n_oe) // [R2]
    else $error("fault flag held without fault");
  a_reset_flag_high: assert property (!pin_s_r |=> !fault_n_oe) // [R4]
    else $error("fault flag pulled during reset");
  a_reset_outputs_off: assert property (!pin_s_r |=> high_side_on == 4'h0 && low_side_on == 4'h0) // [R14]
    else $error("switching during reset");
  a_se_no_pulldown: assert property (!pin_s_r && mode_r == PFS_SE4 |=> weak_pull_down_on == 4'h0) // [R15]
    else $error("pull-down in single ended mode");
  a_btl_pulldown: assert property (!pin_s_r && mode_r == PFS_BTL_AD |=> weak_pull_down_on == 4'hF) // [R15]
    else $error("no pull-down in bridge mode during reset");
  a_thermal_trip_holds: assert property (thermal_trip_latch_r && !rst_rise |=> thermal_trip_latch_r) // [R9]
    else $error("thermal latch lost without reset edge");
  a_thermal_trip_clears: assert property (rst_rise && !thermal_trip |=> !thermal_trip_latch_r) // [R20]
    else $error("thermal latch not cleared by reset edge");
  a_warn_hyst: assert property (warn_r && temp_above_hyst |=> warn_r) // [R8]
    else $error("warning cleared above hysteresis level");
  a_warn_flag: assert property (temp_above_warn |=> ##1 thermal_warning_n_oe) // [R7]
    else $error("warning flag not pulled");
  a_ovl_set: assert property (per_cycle_current_limit[0]
                              && g_ch[0].ovl_cnt_r == `PFS_OVL_CNT_W'(OVERLOAD_CYC - 1)
                              |=> ovl_latch_r[0]) // [R11]
    else $error("overload not latched");
  a_bst_high_off: assert property (bootstrap_cap_low[1] |=> !high_side_on[1]) // [R13]
    else $error("high side on with low bootstrap");
  a_stale_off: assert property (stale_r[2] |=> !high_side_on[2] && !low_side_on[2]) // [R12]
    else $error("channel switching without input PWM");

  c_reset_edge: cover property (rst_rise);
  c_thermal_trip_trip: cover property (!thermal_trip_latch_r ##1 thermal_trip_latch_r);
  c_overload: cover property (!ovl_latch_r[0] ##1 ovl_latch_r[0]);
  c_all_stale: cover property (all_stale && pin_s_r && !uv_r);

endmodule

/* verification/pfs_far_side.sv */
// Purpose: Far side model, PWM modulator and reset controller
// Assumes: Flag pins already resolved with their pull-ups
// Notes:   HOLD_CYC is the scaled fault-to-reset-rise spacing
`timescale 1ns/1ps

module pfs_far_side
#(
  parameter int HOLD_CYC = 40,
  parameter int PWM_HALF = 3
)
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       fault_n,
  input  wire logic       warn_n,
  input  wire logic [3:0] pwm_stop,
  input  wire logic       hold_low,
  output logic [3:0]      pwm_in,
  output logic            reset_pin_n
);
  logic [15:0] since_fall_r;
  logic [7:0]  pwm_cnt_r;
  logic        fault_q_r;

  // ----------------------------------------------------------------
  // PWM source, stopped channels stick
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pwm_cnt_r <= 8'h00;
      pwm_in    <= 4'h0;
    end
    else if (pwm_cnt_r == 8'(PWM_HALF - 1))
    begin
      pwm_cnt_r <= 8'h00;
      pwm_in    <= pwm_in ^ ~pwm_stop;
    end
    else
      pwm_cnt_r <= pwm_cnt_r + 8'h01;
  end

  // ----------------------------------------------------------------
  // Reset controller
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      since_fall_r <= 16'(HOLD_CYC);
      fault_q_r    <= 1'b1;
      reset_pin_n  <= 1'b0;
    end
    else
    begin
      fault_q_r <= fault_n;
      if (fault_q_r && !fault_n)
        since_fall_r <= 16'h0000;
      else if (since_fall_r < 16'(HOLD_CYC))
        since_fall_r <= since_fall_r + 16'h0001;
      if (hold_low)
        reset_pin_n <= 1'b0;
      else if (since_fall_r >= 16'(HOLD_CYC) && warn_n)
        reset_pin_n <= 1'b1;
    end
  end
endmodule

/* verification/pfs_supervisor_test.sv */
// Purpose: Self-checking bench of the power stage fault supervisor
// Assumes: Strap set per scenario, overload count scaled down
// Notes:   Checks on the falling edge, bus answers on the rising edge
`timescale 1ns/1ps

module pfs_supervisor_test;
  localparam int OVL = 20;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0;
  logic [3:0]  sup      = 4'h0;
  logic        t_warn   = 1'b0;
  logic        t_hyst   = 1'b0;
  logic        t_trip   = 1'b0;
  logic [3:0]  limit    = 4'h0;
  logic [3:0]  boot_low = 4'h0;
  logic [3:0]  pwm_stop = 4'h0;
  logic [2:0]  strap    = 3'h0;
  logic        hold_low = 1'b1;
  logic        pready, pslverr, reset_pin_n, f_o, f_oe, w_o, w_oe, e;
  logic [31:0] prdata, q;
  logic [3:0]  pwm_in, hs, ls, pd, ah, al;
  int          num_errors = 0;
  int          n_compared = 0;
  wire         fault_n = f_oe ? f_o : 1'b1;
  wire         warn_n  = w_oe ? w_o : 1'b1;

  always #2 core_clk = ~core_clk;

  pfs_supervisor #(.OVERLOAD_CYC(OVL)) u_dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .reset_pin_n(reset_pin_n), .config_pin_0(strap[0]),
    .config_pin_1(strap[1]), .config_pin_2(strap[2]), .gate_drive_supply_low(sup[0]),
    .bridge_power_supply_low(sup[1]), .logic_regulator_supply_low(sup[2]),
    .analog_regulator_supply_low(sup[3]), .temp_above_warn(t_warn), .temp_above_hyst(t_hyst),
    .thermal_trip(t_trip), .per_cycle_current_limit(limit), .bootstrap_cap_low(boot_low),
    .pwm_in(pwm_in), .high_side_on(hs), .low_side_on(ls), .weak_pull_down_on(pd),
    .fault_n_o(f_o), .fault_n_oe(f_oe), .thermal_warning_n_o(w_o),
    .thermal_warning_n_oe(w_oe));

  pfs_far_side u_far (.core_clk(core_clk), .rst(rst), .fault_n(fault_n), .warn_n(warn_n),
    .pwm_stop(pwm_stop), .hold_low(hold_low), .pwm_in(pwm_in), .reset_pin_n(reset_pin_n));

  task automatic results;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      num_errors++;
      $display("CHECK FAILED apb_ready expected 1 seen %b", pready);
      results();
    end
  endtask

  // Accumulate per-channel switching over a window
  task automatic sw(input logic [3:0] exp);
    ah = 4'h0;
    al = 4'h0;
    repeat (16)
    begin
      @(negedge core_clk);
      ah = ah | hs;
      al = al | ls;
    end
    chk("active", exp, ah | al);
  endtask

  task automatic pulse(input logic [3:0] exp_pd);
    int n;
    n = 0;
    @(posedge core_clk);
    hold_low <= 1'b1;
    cyc(4);
    chk("fault_in_reset", 1, fault_n);
    chk("bridge_in_reset", 0, {hs, ls});
    chk("pull_down", exp_pd, pd);
    @(posedge core_clk);
    hold_low <= 1'b0;
    while (reset_pin_n !== 1'b1 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 200)
    begin
      num_errors++;
      $display("CHECK FAILED reset_release expected 1 seen %b", reset_pin_n);
      results();
    end
    cyc(5);
  endtask

  initial
  begin
    cyc(15);
    @(posedge core_clk);
    rst      <= 1'b0;
    hold_low <= 1'b0;
    cyc(30);
    sw(4'hF);
    chk("flags_idle", 2'h3, {fault_n, warn_n});
    apb(0, 12'h000, 0);
    chk("ctrl_reset", 0, q);
    apb(0, 12'h004, 0);
    chk("status_mode", 0, q);
    apb(1, 12'h000, 32'h5);
    sw(4'hA);
    apb(1, 12'h000, 0);
    apb(0, 12'h008, 0);
    chk("unmapped_err", 1, e);
    apb(1, 12'h004, 32'hF);
    chk("ro_err", 1, e);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      sup <= 4'h1 << i;
      cyc(3);
      chk("bridge_uv", 0, {hs, ls});
      chk("fault_uv", 0, fault_n);
      @(posedge core_clk);
      sup <= 4'h0;
      cyc(3);
      chk("fault_back", 1, fault_n);
      sw(4'hF);
    end
    @(posedge core_clk);
    t_warn <= 1'b1;
    t_hyst <= 1'b1;
    cyc(3);
    chk("warn_only", 2'h2, {fault_n, warn_n});
    sw(4'hF);
    @(posedge core_clk);
    t_warn <= 1'b0;
    cyc(3);
    chk("warn_hyst", 0, warn_n);
    @(posedge core_clk);
    t_trip <= 1'b1;
    cyc(3);
    chk("both_low", 0, {fault_n, warn_n});
    @(posedge core_clk);
    t_trip <= 1'b0;
    t_hyst <= 1'b0;
    cyc(3);
    chk("warn_off", 1, warn_n);
    chk("trip_latched", 0, fault_n);
    sw(4'h0);
    apb(0, 12'h004, 0);
    chk("trip_status", 32'h800, q);
    pulse(4'hF);
    sw(4'hF);
    chk("trip_clear", 1, fault_n);
    @(posedge core_clk);
    limit <= 4'h1;
    repeat (OVL - 2) @(posedge core_clk);
    limit <= 4'h0;
    cyc(3);
    chk("ovl_short", 1, fault_n);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge core_clk);
      limit <= 4'h1 << (3 * k);
      repeat (OVL + 2) @(posedge core_clk);
      limit <= 4'h0;
      cyc(3);
      chk("ovl_fault", 0, fault_n);
      sw(k ? 4'h3 : 4'hC);
      apb(0, 12'h004, 0);
      chk("ovl_status", 32'h40 << (3 * k), q);
      if (k == 0)
        pulse(4'hF);
      else
      begin
        @(posedge core_clk);
        rst <= 1'b1;
        cyc(2);
        @(posedge core_clk);
        rst <= 1'b0;
        cyc(30);
        apb(0, 12'h004, 0);
        chk("por_clear", 0, q);
      end
      sw(4'hF);
    end
    @(posedge core_clk);
    boot_low <= 4'h2;
    cyc(3);
    sw(4'hF);
    chk("high_side", 4'hD, ah);
    chk("boot_fault", 1, fault_n);
    @(posedge core_clk);
    boot_low <= 4'h0;
    cyc(3);
    sw(4'hF);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge core_clk);
      pwm_stop <= k ? 4'hF : 4'h2;
      cyc(1010);
      chk("loss_fault", 1, fault_n);
      sw(k ? 4'h0 : 4'hD);
      apb(0, 12'h004, 0);
      chk("loss_status", k ? 32'h3C : 32'h8, q);
      @(posedge core_clk);
      pwm_stop <= 4'h0;
      cyc(10);
      sw(4'hF);
    end
    // Paralleled bridge, then four single ended
    for (int m = 4; m < 6; m++)
    begin
      @(posedge core_clk);
      strap <= 3'(m);
      rst   <= 1'b1;
      cyc(2);
      @(posedge core_clk);
      rst <= 1'b0;
      cyc(30);
      apb(0, 12'h004, 0);
      chk("mode_strap", 32'(m) << 13, q);
      @(posedge core_clk);
      limit <= 4'h1;
      repeat (OVL + 2) @(posedge core_clk);
      limit <= 4'h0;
      cyc(3);
      chk("mode_ovl_fault", 0, fault_n);
      sw(m == 4 ? 4'h0 : 4'hC);
      pulse(m == 4 ? 4'hF : 4'h0);
      sw(4'hF);
    end
    results();
  end
endmodule
